// *** hw/dms_pkg.sv ***
// Constants, types and register map of the multiply/accumulate slice.
// Assumes a 32-bit APB register bus and one system clock.
package dms_pkg;

    localparam int OP_W   = 9;
    localparam int PROD_W = 18;
    localparam int ACC_W  = 24;
    localparam int NFLAG  = 7;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAGE = 8'h04;
    localparam logic [7:0] A_MASK  = 8'h08;
    localparam logic [7:0] A_PAT   = 8'h0C;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_IMSK  = 8'h14;
    localparam logic [7:0] A_FLAG  = 8'h18;
    localparam logic [7:0] A_RES   = 8'h1C;

    // Control register fields
    localparam int CT_ELEM  = 0;
    localparam int CT_IN    = 2;
    localparam int CT_PIPE  = 3;
    localparam int CT_OUT   = 4;
    localparam int CT_DYN   = 5;
    localparam int CT_SUB   = 6;
    localparam int CT_SHIFT = 7;
    localparam int CTRL_W   = 8;

    // Stage select register: one byte per stage, input/pipeline/output
    localparam int STG_IN   = 0;
    localparam int STG_PIPE = 8;
    localparam int STG_OUT  = 16;
    localparam int STG_W    = 6;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h1C;
    localparam logic [23:0]       STAGE_RST = 24'h000000;
    localparam logic [ACC_W-1:0]  MASK_RST  = 24'hFFFFFF;
    localparam logic [ACC_W-1:0]  PAT_RST   = 24'h000000;
    localparam logic [NFLAG-1:0]  IMSK_RST  = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        EL_PLAIN_MULTIPLY,
        EL_MULTIPLY_ACCUMULATE,
        EL_PAIRED_ADDSUB,
        EL_TWO_SLICE_SUM
    } dms_elem_e;

    typedef struct packed {
        logic [OP_W-1:0] ax;
        logic [OP_W-1:0] ay;
        logic [OP_W-1:0] bx;
        logic [OP_W-1:0] by;
    } dms_op_s;

    typedef struct packed {
        logic [1:0] rst_sel;
        logic [1:0] ce_sel;
        logic [1:0] clk_sel;
    } dms_stg_s;

    typedef struct packed {
        logic under;
        logic over;
        logic inverse_pattern_match_flag;
        logic pattern_match_flag;
        logic masked_ones_flag;
        logic masked_zero_flag;
        logic zero_result_flag;
    } dms_flag_s;

endpackage

// *** hw/dms_stage_ctl.sv ***
// Clock, clock enable and reset selection for one register stage.
// Clock sources are one-cycle enable pulses in the system clock domain.
`timescale 1ns/100ps
module dms_stage_ctl (
    input  wire logic            en_i,
    input  wire dms_pkg::dms_stg_s cfg_i,
    input  wire logic [3:0]      clk_src_i,
    input  wire logic [3:0]      ce_src_i,
    input  wire logic [3:0]      rst_src_i,
    output logic                 tick_o,
    output logic                 clr_o
);
    wire edge_sel = clk_src_i[cfg_i.clk_sel];
    wire ce_sel   = ce_src_i[cfg_i.ce_sel];
    wire rst_sel  = rst_src_i[cfg_i.rst_sel];

    // A bypassed stage follows every system clock
    assign tick_o = ~en_i | (edge_sel & ce_sel);
    assign clr_o  = en_i & edge_sel & rst_sel;
endmodule

// *** hw/dms_flag_unit.sv ***
// Result comparison flags of the ALU.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/100ps
module dms_flag_unit (
    input  wire logic [dms_pkg::ACC_W-1:0] res_i,
    input  wire logic [dms_pkg::ACC_W-1:0] mask_i,
    input  wire logic [dms_pkg::ACC_W-1:0] pat_i,
    input  wire logic                      over_i,
    input  wire logic                      under_i,
    output dms_pkg::dms_flag_s             flag_o
);
    // Mask bits at one take part in the comparison
    wire [dms_pkg::ACC_W-1:0] rm = res_i & mask_i;

    assign flag_o.zero_result_flag    = (res_i == '0);
    assign flag_o.masked_zero_flag   = (rm == '0);
    assign flag_o.masked_ones_flag   = (rm == mask_i);
    assign flag_o.pattern_match_flag  = (((res_i ^ pat_i) & mask_i) == '0);
    assign flag_o.inverse_pattern_match_flag = (((res_i ^ ~pat_i) & mask_i) == '0);
    assign flag_o.over   = over_i;
    assign flag_o.under  = under_i;
endmodule

// *** hw/dms_slice.sv ***
// Multiply/accumulate slice: operand, pipeline and output stages, ALU,
// flags, APB registers and interrupt.
// Assumes synchronous fabric inputs; clock sources are enable pulses.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps

// Notes on behaviour
// - Four elements: multiply, accumulate, paired add/sub, two-slice sum.
// - Paired element adds or subtracts second pair product to first.
// - In summing mode each slice forms its own paired sum or difference.
// - Second ALU adds own result to the cascaded result of slice 0.
// - Input, pipeline and output stages are each enabled or bypassed.
// - Operand registers load in parallel or shift from previous ones.
// - Dynamic mode lets an input pick add or subtract every cycle.
// - Dynamic mode lets an input pick parallel or shift loading.
// - Flags: result zero, masked zero, masked all ones.
// - Flags: masked result equals pattern, or inverted pattern.
// - Separate overflow and underflow flags plus a combined flag.
// - Each stage picks one of four clock sources.
// - Each stage picks its own clock enable and reset source.
// - One slice is half a summing pair; cascade joins two slices.
module dms_slice (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic [3:0]                fab_clk_src_i,
    input  wire logic [3:0]                ce_src_i,
    input  wire logic [3:0]                rst_src_i,
    input  wire dms_pkg::dms_op_s          operand_i,
    input  wire logic [dms_pkg::OP_W-1:0]  shift_x_i,
    input  wire logic [dms_pkg::OP_W-1:0]  shift_y_i,
    output logic      [dms_pkg::OP_W-1:0]  shift_x_o,
    output logic      [dms_pkg::OP_W-1:0]  shift_y_o,
    input  wire logic                      dyn_sub_i,
    input  wire logic                      dyn_shift_i,
    input  wire logic [dms_pkg::ACC_W-1:0] cascade_i,
    output logic      [dms_pkg::ACC_W-1:0] result_o,
    output dms_pkg::dms_flag_s             flags_o,
    output logic                           range_err_o,
    output logic                           irq_o
);
    localparam int AW = dms_pkg::ACC_W;

    // Signed product of two operands, sign-extended to the accumulator
    function automatic logic [AW-1:0] mul_ext(
        input logic [dms_pkg::OP_W-1:0] a,
        input logic [dms_pkg::OP_W-1:0] b);
        logic signed [dms_pkg::PROD_W-1:0] p;
        p = $signed(a) * $signed(b);
        return AW'(p);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic [1:0] rst_sync_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_sync_q <= 2'b00;
        else          rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    wire rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [dms_pkg::CTRL_W-1:0] ctrl_q;
    logic [23:0]                stage_q;
    logic [AW-1:0]              mask_q;
    logic [AW-1:0]              pat_q;
    logic [dms_pkg::NFLAG-1:0]  stat_q;
    logic [dms_pkg::NFLAG-1:0]  imsk_q;

    wire dms_pkg::dms_elem_e elem =
        dms_pkg::dms_elem_e'(ctrl_q[dms_pkg::CT_ELEM +: 2]);
    wire in_en   = ctrl_q[dms_pkg::CT_IN];
    wire pipe_en = ctrl_q[dms_pkg::CT_PIPE];
    wire out_en  = ctrl_q[dms_pkg::CT_OUT];
    wire dyn     = ctrl_q[dms_pkg::CT_DYN];

    wire sub_sel   = dyn ? dyn_sub_i : ctrl_q[dms_pkg::CT_SUB];
    wire shift_sel = dyn ? dyn_shift_i : ctrl_q[dms_pkg::CT_SHIFT];

    ////////////////////////////////////////////////////////////////////////
    // Stage clock, enable and reset selection
    logic in_tick, in_clr, pipe_tick, pipe_clr, out_tick, out_clr;

    dms_stage_ctl u_stg_in (
        .en_i      (in_en),
        .cfg_i     (stage_q[dms_pkg::STG_IN +: dms_pkg::STG_W]),
        .clk_src_i (fab_clk_src_i),
        .ce_src_i  (ce_src_i),
        .rst_src_i (rst_src_i),
        .tick_o    (in_tick),
        .clr_o     (in_clr)
    );
    dms_stage_ctl u_stg_pipe (
        .en_i      (pipe_en),
        .cfg_i     (stage_q[dms_pkg::STG_PIPE +: dms_pkg::STG_W]),
        .clk_src_i (fab_clk_src_i),
        .ce_src_i  (ce_src_i),
        .rst_src_i (rst_src_i),
        .tick_o    (pipe_tick),
        .clr_o     (pipe_clr)
    );
    dms_stage_ctl u_stg_out (
        .en_i      (out_en),
        .cfg_i     (stage_q[dms_pkg::STG_OUT +: dms_pkg::STG_W]),
        .clk_src_i (fab_clk_src_i),
        .ce_src_i  (ce_src_i),
        .rst_src_i (rst_src_i),
        .tick_o    (out_tick),
        .clr_o     (out_clr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Input stage: parallel load or shift from the previous registers
    dms_pkg::dms_op_s in_q;
    dms_pkg::dms_op_s in_d;
    logic             sub_in_q;

    assign in_d.ax = shift_sel ? shift_x_i : operand_i.ax;
    assign in_d.ay = shift_sel ? shift_y_i : operand_i.ay;
    assign in_d.bx = shift_sel ? in_q.ax   : operand_i.bx;
    assign in_d.by = shift_sel ? in_q.ay   : operand_i.by;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            in_q     <= '0;
            sub_in_q <= 1'b0;
        end else if (in_clr) begin
            in_q     <= '0;
            sub_in_q <= 1'b0;
        end else if (in_tick) begin
            in_q     <= in_d;
            sub_in_q <= sub_sel;
        end
    end

    wire dms_pkg::dms_op_s op_use  = in_en ? in_q : in_d;
    wire                   sub_stg = in_en ? sub_in_q : sub_sel;

    ////////////////////////////////////////////////////////////////////////
    // Multipliers and pipeline stage
    wire [AW-1:0] pa_d = mul_ext(op_use.ax, op_use.ay);
    wire [AW-1:0] pb_d = mul_ext(op_use.bx, op_use.by);
    logic [AW-1:0] pa_q, pb_q;
    logic          sub_pipe_q;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pa_q <= '0;
            pb_q <= '0;
            sub_pipe_q <= 1'b0;
        end else if (pipe_clr) begin
            pa_q <= '0;
            pb_q <= '0;
            sub_pipe_q <= 1'b0;
        end else if (pipe_tick) begin
            pa_q <= pa_d;
            pb_q <= pb_d;
            sub_pipe_q <= sub_stg;
        end
    end

    wire [AW-1:0] pa  = pipe_en ? pa_q : pa_d;
    wire [AW-1:0] pb  = pipe_en ? pb_q : pb_d;
    wire          sub = pipe_en ? sub_pipe_q : sub_stg;

    ////////////////////////////////////////////////////////////////////////
    // ALU
    logic [AW-1:0] result_q;
    logic          over_q, under_q;

    wire [AW-1:0] pair_res = sub ? pa - pb : pa + pb;
    wire [AW-1:0] sum_res  = pair_res + cascade_i;
    wire [AW:0]   acc_ext  = sub
        ? {result_q[AW-1], result_q} - {pa[AW-1], pa}
        : {result_q[AW-1], result_q} + {pa[AW-1], pa};
    wire acc_over  = ~acc_ext[AW] & acc_ext[AW-1];
    wire acc_under = acc_ext[AW] & ~acc_ext[AW-1];

    logic [AW-1:0] alu_d;
    logic          over_d, under_d;
    always_comb begin
        over_d  = 1'b0;
        under_d = 1'b0;
        unique case (elem)
            dms_pkg::EL_PLAIN_MULTIPLY: alu_d = pa;
            dms_pkg::EL_MULTIPLY_ACCUMULATE: begin
                alu_d   = acc_ext[AW-1:0];
                over_d  = acc_over;
                under_d = acc_under;
            end
            dms_pkg::EL_PAIRED_ADDSUB: alu_d = pair_res;
            dms_pkg::EL_TWO_SLICE_SUM: alu_d = sum_res;
        endcase
    end

    // Output stage; also the accumulator
    logic out_upd_q;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
            over_q   <= 1'b0;
            under_q  <= 1'b0;
        end else if (out_clr) begin
            result_q <= '0;
            over_q   <= 1'b0;
            under_q  <= 1'b0;
        end else if (out_tick) begin
            result_q <= alu_d;
            over_q   <= over_d;
            under_q  <= under_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags
    dms_pkg::dms_flag_s flag_d;
    dms_pkg::dms_flag_s flags_q;
    logic               range_q;

    dms_flag_unit u_flags (
        .res_i   (result_q),
        .mask_i  (mask_q),
        .pat_i   (pat_q),
        .over_i  (over_q),
        .under_i (under_q),
        .flag_o  (flag_d)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_q   <= '0;
            range_q   <= 1'b0;
            out_upd_q <= 1'b0;
        end else begin
            flags_q   <= flag_d;
            range_q   <= flag_d.over | flag_d.under;
            out_upd_q <= out_tick | out_clr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped offsets
    logic        pready_q, pslverr_q, irq_q;
    logic [31:0] prdata_q;

    wire setup = psel_i & ~penable_i;
    wire wr    = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
    wire w_ctrl  = wr & (paddr_i == dms_pkg::A_CTRL);
    wire w_stage = wr & (paddr_i == dms_pkg::A_STAGE);
    wire w_mask  = wr & (paddr_i == dms_pkg::A_MASK);
    wire w_pat   = wr & (paddr_i == dms_pkg::A_PAT);
    wire w_stat  = wr & (paddr_i == dms_pkg::A_STAT);
    wire w_imsk  = wr & (paddr_i == dms_pkg::A_IMSK);

    logic [31:0] rd_mux;
    logic        hit;
    always_comb begin
        hit    = 1'b1;
        rd_mux = '0;
        case (paddr_i)
            dms_pkg::A_CTRL:  rd_mux = 32'(ctrl_q);
            dms_pkg::A_STAGE: rd_mux = 32'(stage_q);
            dms_pkg::A_MASK:  rd_mux = 32'(mask_q);
            dms_pkg::A_PAT:   rd_mux = 32'(pat_q);
            dms_pkg::A_STAT:  rd_mux = 32'(stat_q);
            dms_pkg::A_IMSK:  rd_mux = 32'(imsk_q);
            dms_pkg::A_FLAG:  rd_mux = 32'({range_q, flags_q});
            dms_pkg::A_RES:   rd_mux = 32'(result_q);
            default:          hit    = 1'b0;
        endcase
    end

    // Events set sticky bits on each output update; set beats clear
    wire [dms_pkg::NFLAG-1:0] evt = flag_d & {dms_pkg::NFLAG{out_upd_q}};
    wire [dms_pkg::NFLAG-1:0] stat_d =
        (stat_q & ~(w_stat ? pwdata_i[dms_pkg::NFLAG-1:0] : '0)) | evt;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= dms_pkg::CTRL_RST;
            stage_q   <= dms_pkg::STAGE_RST;
            mask_q    <= dms_pkg::MASK_RST;
            pat_q     <= dms_pkg::PAT_RST;
            imsk_q    <= dms_pkg::IMSK_RST;
            stat_q    <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            irq_q     <= 1'b0;
        end else begin
            if (w_ctrl)  ctrl_q  <= pwdata_i[dms_pkg::CTRL_W-1:0];
            if (w_stage) stage_q <= pwdata_i[23:0];
            if (w_mask)  mask_q  <= pwdata_i[AW-1:0];
            if (w_pat)   pat_q   <= pwdata_i[AW-1:0];
            if (w_imsk)  imsk_q  <= pwdata_i[dms_pkg::NFLAG-1:0];
            stat_q    <= stat_d;
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q  <= setup ? rd_mux : '0;
            irq_q     <= |(stat_d & imsk_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata_o    = prdata_q;
    assign pready_o    = pready_q;
    assign pslverr_o   = pslverr_q;
    assign shift_x_o   = in_q.bx;
    assign shift_y_o   = in_q.by;
    assign result_o    = result_q;
    assign flags_o     = flags_q;
    assign range_err_o = range_q;
    assign irq_o       = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    wire all_byp = ~in_en & ~pipe_en;
    wire out_go  = out_tick & ~out_clr;

    plain_multiply_element_result_a: assert property (
        all_byp && elem == dms_pkg::EL_PLAIN_MULTIPLY && out_go
        |=> result_q == $past(mul_ext(operand_i.ax, operand_i.ay))
            || $past(shift_sel))
        else $error("multiply result wrong");

    pair_result_a: assert property (
        all_byp && elem == dms_pkg::EL_PAIRED_ADDSUB && out_go && !shift_sel
        |=> result_q == ($past(sub_sel)
            ? $past(mul_ext(operand_i.ax, operand_i.ay))
              - $past(mul_ext(operand_i.bx, operand_i.by))
            : $past(mul_ext(operand_i.ax, operand_i.ay))
              + $past(mul_ext(operand_i.bx, operand_i.by))))
        else $error("paired add/sub result wrong");

    cascade_sum_a: assert property (
        elem == dms_pkg::EL_TWO_SLICE_SUM && out_go
        |=> result_q == $past(pair_res) + $past(cascade_i))
        else $error("cascade sum wrong");

    shift_load_a: assert property (
        in_tick && !in_clr && shift_sel
        |=> in_q.bx == $past(in_q.ax) && in_q.ax == $past(shift_x_i))
        else $error("shift load wrong");

    dyn_sub_a: assert property (
        dyn && dyn_sub_i && all_byp && !shift_sel && out_go
        && elem == dms_pkg::EL_MULTIPLY_ACCUMULATE
        |=> result_q == $past(result_q)
            - $past(mul_ext(operand_i.ax, operand_i.ay)))
        else $error("dynamic subtract ignored");

    dyn_load_a: assert property (
        dyn && in_tick && !in_clr
        |=> in_q.ay == $past(dyn_shift_i ? shift_y_i : operand_i.ay))
        else $error("dynamic load select ignored");

    zero_flag_a: assert property (
        result_q == '0 |=> flags_q.zero_result_flag ##1 1)
        else $error("zero flag missing");

    pattern_flag_a: assert property (
        ((result_q ^ pat_q) & mask_q) == '0 |=> flags_q.pattern_match_flag)
        else $error("pattern flag missing");

    range_flag_a: assert property (
        range_err_o == (flags_q.over | flags_q.under))
        else $error("combined range flag wrong");

    ovf_detect_a: assert property (
        elem == dms_pkg::EL_MULTIPLY_ACCUMULATE && out_go && acc_over
        |=> over_q ##1 flags_q.over)
        else $error("overflow not flagged");

    stage_hold_a: assert property (
        out_en && !out_tick && !out_clr |=> $stable(result_q))
        else $error("enabled output stage moved without clock");

    stage_reset_a: assert property (
        out_clr |=> result_q == '0)
        else $error("stage reset ignored");

    mac_run_c: cover property (
        elem == dms_pkg::EL_MULTIPLY_ACCUMULATE && out_go [*3]);
    sum_c: cover property (elem == dms_pkg::EL_TWO_SLICE_SUM && out_go);
    ovf_c: cover property (flags_q.over ##1 irq_o);
    shift_c: cover property (in_tick && shift_sel ##1 in_tick && !shift_sel);
endmodule

// *** tb/dms_fabric_model.sv ***
// Fabric-side partner of the slice: clock-source pulses, enables, resets.
// Assumes the system clock and an active-low reset from the bench.
`timescale 1ns/100ps
module dms_fabric_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       stage_rst_i,
    output logic [3:0]      fab_clk_src_o,
    output logic [3:0]      ce_src_o,
    output logic [3:0]      rst_src_o
);
    logic [1:0] cnt_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // Source a pulses every cycle, b every second, c and d every fourth
    assign fab_clk_src_o = {cnt_q == 2'h3, cnt_q == 2'h1, cnt_q[0], 1'b1};
    assign ce_src_o      = 4'hF;
    // Reset source a is under bench control, the others stay idle
    assign rst_src_o     = {3'b000, stage_rst_i};
endmodule

// *** tb/dms_slice_test.sv ***
// Self-checking bench of the multiply/accumulate slice.
// Assumes stages bypassed unless a test enables one; enabling the output stage adds no cycle.
`timescale 1ns/100ps
module dms_slice_test;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slv_err, dyn_sub = 1'b0, irq;
    logic dyn_shift = 1'b0, stage_rst = 1'b0, range_seen = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  clk_src, ce_src, rst_src;
    logic [8:0]  shx = 9'h000, shy = 9'h000, sho_x, sho_y;
    logic [23:0] casc = 24'h000000, result;
    logic        pready, range_err;
    dms_pkg::dms_op_s   op = '0;
    dms_pkg::dms_flag_s flags;
    int num_errors = 0, compares = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    // The combined range flag only pulses, so remember that it was seen
    always @(posedge clk_sys_i) begin
        if (range_err === 1'b1) range_seen <= 1'b1;
    end

    dms_fabric_model dms_fabric_model_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .fab_clk_src_o(clk_src), .ce_src_o(ce_src),
        .rst_src_o(rst_src), .stage_rst_i(stage_rst));
    dms_slice dms_slice_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(slv_err), .fab_clk_src_i(clk_src),
        .ce_src_i(ce_src), .rst_src_i(rst_src), .operand_i(op),
        .shift_x_i(shx), .shift_y_i(shy), .shift_x_o(sho_x),
        .shift_y_o(sho_y), .dyn_sub_i(dyn_sub), .dyn_shift_i(dyn_shift),
        .cascade_i(casc), .result_o(result), .flags_o(flags),
        .range_err_o(range_err), .irq_o(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = slv_err;
        if (n >= 50) chk(32'h0, 32'h1);
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Apply operands, then look one cycle past the result update
    task automatic opset(input logic [8:0] ax, ay, bx, by, input int hold);
        @(posedge clk_sys_i);
        op <= {ax, ay, bx, by};
        repeat (hold) @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, dms_pkg::A_CTRL, 32'h0);  chk(rd, 32'h0000001C);
        apb(1'b0, dms_pkg::A_MASK, 32'h0);  chk(rd, 32'h00FFFFFF);
        apb(1'b1, dms_pkg::A_PAT, 32'h00123456);
        apb(1'b0, dms_pkg::A_PAT, 32'h0);   chk(rd, 32'h00123456);
        apb(1'b0, 8'h40, 32'h0);  chk({rd[30:0], err}, 32'h00000001);
        $display("test regs done");
    endtask

    task automatic t_plain_multiply_element;
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000000);
        opset(9'h003, 9'h1FB, 9'h000, 9'h000, 2);
        chk(result, 32'h00FFFFF1);
        opset(9'h000, 9'h005, 9'h000, 9'h000, 2);
        chk(flags, 32'h00000003);
        apb(1'b1, dms_pkg::A_PAT, 32'h0);
        @(posedge clk_sys_i);
        #1;
        chk(flags, 32'h0000000B);
        $display("test plain_multiply_element done");
    endtask

    task automatic t_addsub;
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000002);
        opset(9'h007, 9'h009, 9'h1FC, 9'h006, 2);
        chk(result, 32'h00000027);
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000042);
        opset(9'h007, 9'h009, 9'h1FC, 9'h006, 2);
        chk(result, 32'h00000057);
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000003);
        casc <= 24'h000064;
        opset(9'h002, 9'h003, 9'h004, 9'h005, 2);
        chk(result, 32'h0000007E);
        $display("test addsub done");
    endtask

    task automatic t_mac;
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000000);
        opset(9'h000, 9'h000, 9'h000, 9'h000, 2);
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000021);
        dyn_sub <= 1'b1;
        opset(9'h002, 9'h003, 9'h000, 9'h000, 4);
        opset(9'h000, 9'h000, 9'h000, 9'h000, 2);
        chk(result, 32'h00FFFFE2);
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000000);
        apb(1'b1, dms_pkg::A_STAT, 32'h0000007F);
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000021);
        dyn_sub <= 1'b0;
        opset(9'h100, 9'h100, 9'h000, 9'h000, 127);
        opset(9'h000, 9'h000, 9'h000, 9'h000, 2);
        chk(result, 32'h00800000);
        apb(1'b0, dms_pkg::A_STAT, 32'h0);
        chk(rd & 32'h60, 32'h00000020);
        chk(range_seen, 32'h1);
        $display("test mac done");
    endtask

    task automatic t_irq;
        chk(irq, 32'h0);
        apb(1'b1, dms_pkg::A_IMSK, 32'h00000020);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(irq, 32'h1);
        apb(1'b1, dms_pkg::A_STAT, 32'h0000007F);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(irq, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_shift;
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000020);
        shx <= 9'h003;
        shy <= 9'h004;
        dyn_shift <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(sho_x, 32'h00000003);
        chk(sho_y, 32'h00000004);
        chk(result, 32'h0000000C);
        @(posedge clk_sys_i);
        dyn_shift <= 1'b0;
        opset(9'h002, 9'h005, 9'h000, 9'h000, 2);
        chk(result, 32'h0000000A);
        $display("test shift done");
    endtask

    // Output stage enabled: stage reset, then a slower clock source
    task automatic t_stage;
        apb(1'b1, dms_pkg::A_CTRL, 32'h00000010);
        opset(9'h003, 9'h003, 9'h000, 9'h000, 2);
        chk(result, 32'h00000009);
        @(posedge clk_sys_i);
        stage_rst <= 1'b1;
        @(posedge clk_sys_i);
        stage_rst <= 1'b0;
        #1;
        chk(result, 32'h00000000);
        apb(1'b1, dms_pkg::A_STAGE, 32'h00020000);
        opset(9'h002, 9'h002, 9'h000, 9'h000, 5);
        chk(result, 32'h00000004);
        $display("test stage done");
    endtask

    task automatic print_verdict;
        $display("counts: compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #40000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_regs();
        t_plain_multiply_element();
        t_addsub();
        t_mac();
        t_irq();
        t_shift();
        t_stage();
        print_verdict();
    end
endmodule
